// >>> verilog/dfcs_pkg.sv
// Constants, register map and carrier types of the disk format control store
// Assumes one 20 MHz clock and a byte strobe from the surrounding controller
//
// Summary of operation
// - Store holds 32 words of 28 bits
// - Word is control, value, count, error fields
// - Pointer write selects word; window writes advance it
// - Reset leaves store contents unchanged
// - Data-field rise with write or compare prefetches
// - Prefetch pulses also with immediate fill data
// - Error bit 3 stops command on CRC, miscompare or write parity errors
// - Error bit 2 retries sector on read error
// - Error bit 1 selects data checksum, prefetch
// - Error bit 0 drives byte-aligned user output
// - Control bit 7 selects value byte use
// - Control bit 6 selects count byte use
// - Control bit 5 drives write gate
// - Control bit 4 drives read gate via retry
// - Control bit 3 drives mark enable output
// - Control bit 2 enables serial data compare
// - Control bit 1 jumps to branch target
// - Control bit 0 repeats while sectors remain
// - Immediate value byte gives literal field data
// - Immediate count is field length minus one
// - Transfer bit edge decrements sector counter
package dfcs_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] DFCS_ERR_WIN_OFS  = 8'h04;
    localparam logic [7:0] DFCS_CTL_WIN_OFS  = 8'h05;
    localparam logic [7:0] DFCS_VAL_WIN_OFS  = 8'h06;
    localparam logic [7:0] DFCS_CNT_WIN_OFS  = 8'h07;
    localparam logic [7:0] DFCS_PTR_OFS      = 8'h08;
    localparam logic [7:0] DFCS_SEQ_CTL_OFS  = 8'h09;
    localparam logic [7:0] DFCS_BRANCH_OFS   = 8'h0A;
    localparam logic [7:0] DFCS_REPEAT_OFS   = 8'h0B;
    localparam logic [7:0] DFCS_SECTOR_OFS   = 8'h0C;
    localparam logic [7:0] DFCS_STATUS_OFS   = 8'h0D;

    // ------------------------------------------------------------------
    // Sizes and field positions
    // ------------------------------------------------------------------
    localparam int DFCS_DEPTH    = 32;
    localparam int DFCS_AW       = 5;
    localparam int ERR_FAIL      = 3;
    localparam int ERR_RETRY     = 2;
    localparam int ERR_DATA      = 1;
    localparam int ERR_USER      = 0;
    localparam int CTL_VMODE     = 7;
    localparam int CTL_CMODE     = 6;
    localparam int CTL_WGATE     = 5;
    localparam int CTL_RGATE     = 4;
    localparam int CTL_MARK      = 3;
    localparam int CTL_CMP       = 2;
    localparam int CTL_BRANCH    = 1;
    localparam int CTL_REPEAT    = 0;
    localparam int VAL_BUFFER    = 7;
    localparam int VAL_VERIFY    = 6;
    localparam int CNT_STOP      = 0;
    localparam int SEQ_GO        = 0;
    localparam int SEQ_READ_COMPARE_ENABLE      = 1;

    localparam logic [4:0] DFCS_PTR_RST = 5'h00;
    localparam logic [7:0] DFCS_BYTE_RST = 8'h00;

    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] val;
        logic [7:0] cnt;
        logic [3:0] err;
    } dfcs_word_t;

    typedef struct packed {
        logic       write_gate;
        logic       read_gate;
        logic       mark_enable_output;
        logic       compare_enable;
        logic       data_checksum_sel;
        logic       value_byte_mode;
        logic       user_sequencer_output;
        logic [7:0] field_value;
    } dfcs_drive_t;

    typedef enum logic [1:0] {
        DFCS_IDLE = 2'b00,
        DFCS_RUN  = 2'b01,
        DFCS_STOP = 2'b10
    } dfcs_state_t;

endpackage

// >>> verilog/dfcs_store.sv
// Control store, its windows and the sequencer that walks it
// Assumes byte strobe and error pulses come from logic on clk
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module dfcs_store (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output var  logic [7:0]           reg_rdata,
    input  wire logic                 byte_strobe,
    input  wire logic [3:0]           wait_cond_pin,
    input  wire logic                 crc_error,
    input  wire logic                 miscompare_error,
    input  wire logic                 write_parity_error,
    input  wire logic                 read_error,
    output var  dfcs_pkg::dfcs_drive_t drive,
    output var  logic                 buffer_request_pulse,
    output var  logic                 sector_step_pulse,
    output var  logic                 retry_pulse,
    output var  logic                 busy
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    dfcs_pkg::dfcs_word_t   store [dfcs_pkg::DFCS_DEPTH];
    dfcs_pkg::dfcs_word_t   cur;
    dfcs_pkg::dfcs_word_t   ptr_word;
    dfcs_pkg::dfcs_state_t  state_q;
    logic [4:0]             ptr_q;
    logic [4:0]             pc_q;
    logic [4:0]             branch_q;
    logic [4:0]             repeat_q;
    logic [7:0]             sector_q;
    logic [7:0]             byte_cnt_q;
    logic                   read_compare_enable_q;
    logic                   err_stop_q;
    logic                   dac_prev_q;
    logic                   xfer_prev_q;
    logic [3:0]             cond_meta_q;
    logic [3:0]             cond_q;
    logic                   running;
    logic                   win_wr;
    logic                   fail_hit;
    logic                   retry_hit;
    logic                   step_done;
    logic                   stop_now;
    logic                   xfer_bit;
    logic                   go_wr;
    logic [4:0]             next_pc;

    assign cur      = store[pc_q];
    assign ptr_word = store[ptr_q];
    assign running  = (state_q == dfcs_pkg::DFCS_RUN);
    assign go_wr    = reg_wr && (reg_addr == dfcs_pkg::DFCS_SEQ_CTL_OFS)
                      && reg_wdata[dfcs_pkg::SEQ_GO];
    assign win_wr   = reg_wr && (reg_addr >= dfcs_pkg::DFCS_ERR_WIN_OFS)
                      && (reg_addr <= dfcs_pkg::DFCS_CNT_WIN_OFS);

    // ------------------------------------------------------------------
    // Store and window writes
    // ------------------------------------------------------------------
    // No reset here, so contents survive a reset
    always_ff @(posedge clk) begin
        if (reg_wr) begin
            unique case (reg_addr)
                dfcs_pkg::DFCS_ERR_WIN_OFS: begin
                    store[ptr_q].err <= reg_wdata[3:0];
                end
                dfcs_pkg::DFCS_CTL_WIN_OFS: begin
                    store[ptr_q].ctl <= reg_wdata;
                end
                dfcs_pkg::DFCS_VAL_WIN_OFS: begin
                    store[ptr_q].val <= reg_wdata;
                end
                dfcs_pkg::DFCS_CNT_WIN_OFS: begin
                    store[ptr_q].cnt <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Pointer load and auto increment
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_q <= dfcs_pkg::DFCS_PTR_RST;
        end else if (reg_wr && reg_addr == dfcs_pkg::DFCS_PTR_OFS) begin
            ptr_q <= reg_wdata[4:0];
        end else if (win_wr) begin
            ptr_q <= ptr_q + 5'd1;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer setup registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            branch_q <= dfcs_pkg::DFCS_PTR_RST;
            repeat_q <= dfcs_pkg::DFCS_PTR_RST;
            read_compare_enable_q   <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == dfcs_pkg::DFCS_BRANCH_OFS) begin
                branch_q <= reg_wdata[4:0];
            end
            if (reg_addr == dfcs_pkg::DFCS_REPEAT_OFS) begin
                repeat_q <= reg_wdata[4:0];
            end
            if (reg_addr == dfcs_pkg::DFCS_SEQ_CTL_OFS) begin
                read_compare_enable_q <= reg_wdata[dfcs_pkg::SEQ_READ_COMPARE_ENABLE];
            end
        end
    end

    // Sector counter; a software write wins over a decrement
    assign xfer_bit = running && cur.ctl[dfcs_pkg::CTL_VMODE]
                      && (cur.val[dfcs_pkg::VAL_BUFFER]
                          || cur.val[dfcs_pkg::VAL_VERIFY]);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sector_q    <= dfcs_pkg::DFCS_BYTE_RST;
            xfer_prev_q <= 1'b0;
        end else begin
            xfer_prev_q <= xfer_bit;
            if (reg_wr && reg_addr == dfcs_pkg::DFCS_SECTOR_OFS) begin
                sector_q <= reg_wdata;
            end else if (xfer_bit && !xfer_prev_q
                         && sector_q != dfcs_pkg::DFCS_BYTE_RST) begin
                sector_q <= sector_q - 8'd1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sector_step_pulse <= 1'b0;
        end else begin
            sector_step_pulse <= xfer_bit && !xfer_prev_q;
        end
    end

    // ------------------------------------------------------------------
    // Wait condition synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cond_meta_q <= 4'h0;
            cond_q      <= 4'h0;
        end else begin
            cond_meta_q <= wait_cond_pin;
            cond_q      <= cond_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Sequencing decisions
    // ------------------------------------------------------------------
    assign fail_hit  = running && cur.err[dfcs_pkg::ERR_FAIL]
                       && (crc_error || miscompare_error
                           || write_parity_error);
    assign retry_hit = running && cur.err[dfcs_pkg::ERR_RETRY]
                       && cur.ctl[dfcs_pkg::CTL_RGATE]
                       && !cur.ctl[dfcs_pkg::CTL_WGATE]
                       && read_error;
    assign stop_now  = running && cur.ctl[dfcs_pkg::CTL_CMODE]
                       && cur.cnt[dfcs_pkg::CNT_STOP];

    always_comb begin
        step_done = 1'b0;
        if (running && cur.ctl[dfcs_pkg::CTL_CMODE]) begin
            step_done = (cur.cnt[7:4] & cond_q) != 4'h0;
        end else if (running && byte_strobe) begin
            step_done = (byte_cnt_q == cur.cnt);
        end
    end

    always_comb begin
        if (cur.ctl[dfcs_pkg::CTL_BRANCH]) begin
            next_pc = branch_q;
        end else if (cur.ctl[dfcs_pkg::CTL_REPEAT]
                     && sector_q != dfcs_pkg::DFCS_BYTE_RST) begin
            next_pc = repeat_q;
        end else begin
            next_pc = pc_q + 5'd1;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer state, program counter and byte counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q    <= dfcs_pkg::DFCS_IDLE;
            pc_q       <= dfcs_pkg::DFCS_PTR_RST;
            byte_cnt_q <= dfcs_pkg::DFCS_BYTE_RST;
            err_stop_q <= 1'b0;
        end else if (go_wr) begin
            state_q    <= dfcs_pkg::DFCS_RUN;
            pc_q       <= ptr_q;
            byte_cnt_q <= dfcs_pkg::DFCS_BYTE_RST;
            err_stop_q <= 1'b0;
        end else begin
            unique case (state_q)
                dfcs_pkg::DFCS_IDLE, dfcs_pkg::DFCS_STOP: begin
                    byte_cnt_q <= dfcs_pkg::DFCS_BYTE_RST;
                end
                dfcs_pkg::DFCS_RUN: begin
                    if (fail_hit) begin
                        state_q    <= dfcs_pkg::DFCS_STOP;
                        err_stop_q <= 1'b1;
                    end else if (stop_now) begin
                        state_q <= dfcs_pkg::DFCS_STOP;
                    end else if (retry_hit) begin
                        pc_q       <= repeat_q;
                        byte_cnt_q <= dfcs_pkg::DFCS_BYTE_RST;
                    end else if (step_done) begin
                        pc_q       <= next_pc;
                        byte_cnt_q <= dfcs_pkg::DFCS_BYTE_RST;
                    end else if (byte_strobe
                                 && !cur.ctl[dfcs_pkg::CTL_CMODE]) begin
                        byte_cnt_q <= byte_cnt_q + 8'd1;
                    end
                end
                default: begin
                    state_q <= dfcs_pkg::DFCS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Drive outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drive.write_gate         <= 1'b0;
            drive.read_gate          <= 1'b0;
            drive.mark_enable_output <= 1'b0;
            drive.compare_enable     <= 1'b0;
            drive.data_checksum_sel  <= 1'b0;
            drive.value_byte_mode    <= 1'b0;
            drive.field_value        <= dfcs_pkg::DFCS_BYTE_RST;
            drive.user_sequencer_output <= 1'b0;
        end else begin
            drive.write_gate <= running
                && cur.ctl[dfcs_pkg::CTL_WGATE];
            // Retry drops read gate for the cycle it restarts
            drive.read_gate <= running && !retry_hit
                && cur.ctl[dfcs_pkg::CTL_RGATE];
            drive.mark_enable_output <= running
                && cur.ctl[dfcs_pkg::CTL_MARK];
            drive.compare_enable <= running
                && cur.ctl[dfcs_pkg::CTL_CMP];
            drive.data_checksum_sel <= cur.err[dfcs_pkg::ERR_DATA];
            drive.value_byte_mode <= cur.ctl[dfcs_pkg::CTL_VMODE];
            drive.field_value <= cur.val;
            // User output moves only on byte boundaries
            if (byte_strobe) begin
                drive.user_sequencer_output <= running
                    && cur.err[dfcs_pkg::ERR_USER];
            end
        end
    end

    // Prefetch on the rising data-field bit, whatever the value mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dac_prev_q           <= 1'b0;
            buffer_request_pulse <= 1'b0;
        end else begin
            dac_prev_q <= running && cur.err[dfcs_pkg::ERR_DATA];
            buffer_request_pulse <= running
                && cur.err[dfcs_pkg::ERR_DATA] && !dac_prev_q
                && (cur.ctl[dfcs_pkg::CTL_WGATE] || read_compare_enable_q);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            retry_pulse <= 1'b0;
            busy        <= 1'b0;
        end else begin
            retry_pulse <= retry_hit;
            busy        <= go_wr || (running && !fail_hit && !stop_now);
        end
    end

    // ------------------------------------------------------------------
    // Register reads, data one cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= dfcs_pkg::DFCS_BYTE_RST;
        end else if (reg_rd) begin
            unique case (reg_addr)
                dfcs_pkg::DFCS_ERR_WIN_OFS: begin
                    reg_rdata <= {4'h0, ptr_word.err};
                end
                dfcs_pkg::DFCS_CTL_WIN_OFS: begin
                    reg_rdata <= ptr_word.ctl;
                end
                dfcs_pkg::DFCS_VAL_WIN_OFS: begin
                    reg_rdata <= ptr_word.val;
                end
                dfcs_pkg::DFCS_CNT_WIN_OFS: begin
                    reg_rdata <= ptr_word.cnt;
                end
                dfcs_pkg::DFCS_PTR_OFS: begin
                    reg_rdata <= {3'h0, ptr_q};
                end
                dfcs_pkg::DFCS_SEQ_CTL_OFS: begin
                    reg_rdata <= {6'h00, read_compare_enable_q, 1'b0};
                end
                dfcs_pkg::DFCS_BRANCH_OFS: begin
                    reg_rdata <= {3'h0, branch_q};
                end
                dfcs_pkg::DFCS_REPEAT_OFS: begin
                    reg_rdata <= {3'h0, repeat_q};
                end
                dfcs_pkg::DFCS_SECTOR_OFS: begin
                    reg_rdata <= sector_q;
                end
                dfcs_pkg::DFCS_STATUS_OFS: begin
                    reg_rdata <= {running, err_stop_q, 1'b0, pc_q};
                end
                default: begin
                    reg_rdata <= dfcs_pkg::DFCS_BYTE_RST;
                end
            endcase
        end else begin
            reg_rdata <= dfcs_pkg::DFCS_BYTE_RST;
        end
    end

endmodule
`default_nettype wire

// >>> bench/dfcs_props.sv
// Port checker for the disk format control store
// Assumes one clock domain; bound onto dfcs_store below
`timescale 1ns/1ns
`default_nettype none
module dfcs_props (
    input wire logic                  clk,
    input wire logic                  arst_n,
    input wire logic [7:0]            reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  byte_strobe,
    input wire logic                  read_error,
    input wire dfcs_pkg::dfcs_drive_t drive,
    input wire logic                  buffer_request_pulse,
    input wire logic                  sector_step_pulse,
    input wire logic                  retry_pulse,
    input wire logic                  busy
);
    // ------------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_rdata_slot: assert property (
        reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data outside its slot");
    chk_go_busy: assert property (
        reg_wr && reg_addr == dfcs_pkg::DFCS_SEQ_CTL_OFS && reg_wdata[0]
        |=> busy)
        else $error("start did not raise busy");
    chk_wg_run: assert property (
        $rose(drive.write_gate) |-> busy || $past(busy))
        else $error("write gate rose while idle");
    chk_idle_quiet: assert property (
        !busy && !$past(busy) && !$past(busy, 2)
        |-> !drive.write_gate && !drive.read_gate
            && !drive.mark_enable_output)
        else $error("gate outputs active while idle");
    chk_req_once: assert property (
        buffer_request_pulse |-> drive.data_checksum_sel
            ##1 !buffer_request_pulse)
        else $error("bad prefetch pulse");
    chk_req_run: assert property (
        buffer_request_pulse |-> busy || $past(busy))
        else $error("prefetch pulse while idle");
    chk_step_once: assert property (
        sector_step_pulse |-> drive.value_byte_mode
            ##1 !sector_step_pulse)
        else $error("bad sector step pulse");
    chk_retry_cause: assert property (
        retry_pulse |-> $past(read_error) || $past(read_error, 2))
        else $error("retry without read error");
    chk_user_byte: assert property (
        busy && $past(busy) && $changed(drive.user_sequencer_output)
        |-> $past(byte_strobe) || $past(byte_strobe, 2))
        else $error("user output moved off a byte boundary");
endmodule

bind dfcs_store dfcs_props chk_u (
    .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .byte_strobe, .read_error, .drive, .buffer_request_pulse,
    .sector_step_pulse, .retry_pulse, .busy
);
`default_nettype wire

// >>> bench/dfcs_drive_model.sv
// Read/write channel model: byte strobes and one-shot error pulses
// Assumes the bench raises a request level to inject one error
`timescale 1ns/1ns
`default_nettype none
module dfcs_drive_model (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic strobe_en,
    input  wire logic crc_req,
    input  wire logic rerr_req,
    output var  logic byte_strobe,
    output var  logic crc_error,
    output var  logic read_error
);
    logic [1:0] div_q;
    logic       crc_q;
    logic       rerr_q;

    // Byte every fourth clock while the channel streams
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q       <= 2'h0;
            byte_strobe <= 1'b0;
        end else begin
            div_q       <= strobe_en ? div_q + 2'h1 : 2'h0;
            byte_strobe <= strobe_en && div_q == 2'h3;
        end
    end

    // One pulse per rising request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            crc_q      <= 1'b0;
            rerr_q     <= 1'b0;
            crc_error  <= 1'b0;
            read_error <= 1'b0;
        end else begin
            crc_q      <= crc_req;
            rerr_q     <= rerr_req;
            crc_error  <= crc_req && !crc_q;
            read_error <= rerr_req && !rerr_q;
        end
    end
endmodule
`default_nettype wire

// >>> bench/dfcs_store_bench.sv
// Register-level bench for the disk format control store
// Assumes the drive model supplies strobes and error pulses
`timescale 1ns/1ns
`default_nettype none
module dfcs_store_bench;
    logic                  clk = 1'b0;
    logic                  arst_n = 1'b0;
    logic [7:0]            reg_addr = 8'h00;
    logic [7:0]            reg_wdata = 8'h00;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic [7:0]            reg_rdata;
    logic                  byte_strobe;
    logic                  crc_error;
    logic                  read_error;
    logic                  strobe_en = 1'b0;
    logic                  crc_req = 1'b0;
    logic                  rerr_req = 1'b0;
    dfcs_pkg::dfcs_drive_t drive;
    logic                  buffer_request_pulse;
    logic                  sector_step_pulse;
    logic                  retry_pulse;
    logic                  busy;
    int                    n_mismatch = 0;
    int                    total_checks = 0;
    int                    n_byte = 0;
    int                    n_req = 0;
    int                    n_step = 0;
    int                    n_retry = 0;
    logic [4:0]            wa [6] = '{5'h02, 5'h03, 5'h05, 5'h07, 5'h09,
                                      5'h0C};
    dfcs_pkg::dfcs_word_t  prog [6] = '{28'h205_A023,
        28'h9EA_0000,
        28'h410_0100, 28'h000_0FF8, 28'h100_0FF4, 28'h400_0010};

    dfcs_drive_model drv_u (
        .clk, .arst_n, .strobe_en, .crc_req, .rerr_req, .byte_strobe,
        .crc_error, .read_error
    );
    dfcs_store dut_u (
        .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .byte_strobe, .wait_cond_pin({3'h0, strobe_en}), .crc_error,
        .miscompare_error(1'b0), .write_parity_error(1'b0), .read_error,
        .drive, .buffer_request_pulse, .sector_step_pulse, .retry_pulse,
        .busy
    );

    always #25 clk = ~clk;

    always @(posedge clk) begin
        n_byte  += int'(byte_strobe === 1'b1);
        n_req   += int'(buffer_request_pulse === 1'b1);
        n_step  += int'(sector_step_pulse === 1'b1);
        n_retry += int'(retry_pulse === 1'b1);
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic peek(input logic [7:0] a, input logic [7:0] e,
                        input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask

    // Loads a word field by field, or reads it back with one pointer set
    task automatic word(input logic [4:0] a, input dfcs_pkg::dfcs_word_t w,
                        input logic check);
        logic [7:0] f [4];
        f = '{{4'h0, w.err}, w.ctl, w.val, w.cnt};
        if (check) wr(dfcs_pkg::DFCS_PTR_OFS, {3'h0, a});
        for (int i = 0; i < 4; i++) begin
            if (check) begin
                peek(dfcs_pkg::DFCS_ERR_WIN_OFS + 8'(i), f[i], "window");
            end else begin
                wr(dfcs_pkg::DFCS_PTR_OFS, {3'h0, a});
                wr(dfcs_pkg::DFCS_ERR_WIN_OFS + 8'(i), f[i]);
            end
        end
    endtask

    task automatic go(input logic [7:0] a);
        wr(dfcs_pkg::DFCS_PTR_OFS, a);
        wr(dfcs_pkg::DFCS_SEQ_CTL_OFS, 8'h01);
    endtask

    task automatic idle();
        for (int k = 0; k < 400 && busy !== 1'b0; k++) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        wr(dfcs_pkg::DFCS_PTR_OFS, 8'h1F);
        wr(dfcs_pkg::DFCS_CTL_WIN_OFS, 8'hC3);
        wr(dfcs_pkg::DFCS_CTL_WIN_OFS, 8'h3C);
        wr(dfcs_pkg::DFCS_PTR_OFS, 8'h1F);
        peek(dfcs_pkg::DFCS_CTL_WIN_OFS, 8'hC3, "ctl w31");
        wr(dfcs_pkg::DFCS_PTR_OFS, 8'h00);
        peek(dfcs_pkg::DFCS_CTL_WIN_OFS, 8'h3C, "ctl w0");
        for (int i = 0; i < 6; i++) word(wa[i], prog[i], 1'b0);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            word(wa[i], prog[i], 1'b1);
        end
        peek(8'h3F, 8'h00, "unmapped");
        wr(dfcs_pkg::DFCS_BRANCH_OFS, 8'h05);
        wr(dfcs_pkg::DFCS_REPEAT_OFS, 8'h0C);
        wr(dfcs_pkg::DFCS_SECTOR_OFS, 8'h02);
        go(8'h02);
        repeat (2) @(posedge clk);
        #1;
        chk("wg", 8'h01, {7'h0, drive.write_gate});
        chk("dsel", 8'h01, {7'h0, drive.data_checksum_sel});
        chk("vmode", 8'h00, {7'h0, drive.value_byte_mode});
        chk("value", 8'h5A, drive.field_value);
        strobe_en <= 1'b1;
        for (int k = 0; k < 200 && drive.read_gate !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk("bytes", 8'h03, 8'(n_byte));
        chk("rg", 8'h01, {7'h0, drive.read_gate});
        chk("cmp", 8'h01, {7'h0, drive.compare_enable});
        chk("mark", 8'h01, {7'h0, drive.mark_enable_output});
        chk("user", 8'h01, {7'h0, drive.user_sequencer_output});
        idle();
        strobe_en <= 1'b0;
        chk("bytes", 8'h04, 8'(n_byte));
        chk("user", 8'h00, {7'h0, drive.user_sequencer_output});
        chk("steps", 8'h01, 8'(n_step));
        chk("reqs", 8'h01, 8'(n_req));
        peek(dfcs_pkg::DFCS_STATUS_OFS, 8'h0C, "pc");
        peek(dfcs_pkg::DFCS_SECTOR_OFS, 8'h01, "sectors");
        go(8'h07);
        strobe_en <= 1'b1;
        crc_req   <= 1'b1;
        @(posedge clk);
        idle();
        crc_req <= 1'b0;
        peek(dfcs_pkg::DFCS_STATUS_OFS, 8'h47, "fail stop");
        go(8'h09);
        repeat (3) @(posedge clk);
        #1;
        chk("rg", 8'h01, {7'h0, drive.read_gate});
        rerr_req <= 1'b1;
        idle();
        chk("retries", 8'h01, 8'(n_retry));
        peek(dfcs_pkg::DFCS_STATUS_OFS, 8'h0C, "retry pc");
        wrap_up();
    end
endmodule
`default_nettype wire
